// >>> dpll_select_pkg.sv
package dpll_select_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_INPUTS = 8;
	localparam int SEL_W = 3;
	localparam int PRIO_W = 4;
	localparam int OFFSET_W = 32;
	localparam int ADDR_W = 8;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] CHANNEL_CONTROL_0_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] REFERENCE_MODE_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] INPUT_ENABLE_ADDR = 8'h08;
	localparam logic [ADDR_W-1:0] INPUT_PRIORITY_ADDR = 8'h0C;
	localparam logic [ADDR_W-1:0] INPUT_GROUP_ADDR = 8'h10;
	localparam logic [ADDR_W-1:0] REFERENCE_CHOICE_ADDR = 8'h14;
	localparam logic [ADDR_W-1:0] HOLDOVER_CONFIG_ADDR = 8'h18;
	localparam logic [ADDR_W-1:0] CHANNEL_CONTROL_2_ADDR = 8'h1C;
	localparam logic [ADDR_W-1:0] MANUAL_HOLDOVER_ADDR = 8'h20;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h24;
	localparam logic [ADDR_W-1:0] HOLDOVER_VALUE_ADDR = 8'h28;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_STATE_LSB = 0;   // operating_state_select [2:0]
	localparam int CTL_REVERTIVE_BIT = 3;
	localparam int CTL_COMBO_BIT = 4;
	localparam int HO_ADVANCED_BIT = 0; // holdover_config
	localparam int HO_RATE_LSB = 8;     // holdover_history_rate [13:8]
	localparam int HO_FILTER_BW_LSB = 16; // holdover_filter_bandwidth [21:16]
	localparam int CHOICE_MANUAL_LSB = 0;
	localparam int CHOICE_FOLLOWER_LSB = 4;
	localparam int CTL2_BW_LSB = 0;     // loop bandwidth index [3:0]
	localparam int CTL2_DAMP_LSB = 8;   // damping index [10:8]
	localparam int ST_STATE_LSB = 0;
	localparam int ST_SEL_LSB = 4;
	localparam int ST_AVAIL_BIT = 7;
	localparam int ST_QUAL_LSB = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CONTROL_0_RESET = 8'h00;
	localparam logic [NUM_INPUTS-1:0] INPUT_ENABLE_RESET = 8'hFF;
	localparam logic [31:0] PRIORITY_RESET = 32'h7654_3210;
	localparam logic [31:0] GROUP_RESET = 32'h0000_0000;
	localparam logic [3:0] BW_RESET = 4'h0;
	localparam logic [2:0] DAMP_RESET = 3'h0;
	localparam logic [5:0] HISTORY_RATE_RESET = 6'h01;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_HZ = 200_000_000;
	localparam int HISTORY_STEP_S = 1;
	localparam int HISTORY_STEP_CYCLES = HISTORY_STEP_S * CLOCK_HZ;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_AUTOMATIC = 3'h0,
		OP_FORCED_LOCKED = 3'h1,
		OP_FORCED_FREERUN = 3'h2,
		OP_FORCED_HOLDOVER = 3'h3,
		OP_MANUAL_HOLDOVER = 3'h4
	} op_select_t;

	typedef enum logic [3:0] {
		REF_AUTOMATIC = 4'h0,
		REF_MANUAL = 4'h1,
		REF_PIN = 4'h2,
		REF_FOLLOWER = 4'h3,
		REF_PIN_FOLLOWER = 4'h4
	} ref_mode_t;

	typedef enum logic [2:0] {
		ST_FREERUN = 3'b000,
		ST_LOCK_ACQUIRE = 3'b001,
		ST_LOCKED = 3'b011,
		ST_HOLDOVER = 3'b010,
		ST_LOCK_RECOVER = 3'b110
	} loop_state_t;

	typedef enum logic [1:0] {
		SRC_OSCILLATOR = 2'h0,
		SRC_REFERENCE = 2'h1,
		SRC_HOLDOVER = 2'h2
	} loop_source_t;

endpackage : dpll_select_pkg

// >>> history_store.sv
module history_store
	import dpll_select_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic wr_addr,
	input wire logic [OFFSET_W-1:0] wr_data,
	input wire logic rd_addr,
	output logic [OFFSET_W-1:0] rd_data
);

	logic [OFFSET_W-1:0] slot_mem [2];

	// Slot write
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			slot_mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_data <= '0;
		end else begin
			rd_data <= slot_mem[rd_addr];
		end
	end

endmodule : history_store

// >>> operating_state_select_and_reference_select.sv
// Contract
// - Free-run output from oscillator only
// - Combo follower free-run uses leader input
// - Locked output tracks selected reference
// - Programmable bandwidth and damping while locked
// - Holdover when all available references invalid
// - Simple or advanced holdover source selectable
// - Two history slots, older loaded on entry
// - History interval 0 to 63 seconds
// - Forced holdover ignores valid references
// - Manual holdover uses software offset value
// - Any input selectable, independent per channel
// - Reference mode codes decode, rest reserved
// - Automatic picks enabled valid highest priority
// - Manual selects by register or pins
// - Manual invalid input forces holdover
// - Follower uses only designated input
// - Pin follower switches on pin status
// - Non-revertive default, leave only when invalid
// - Revertive moves up, not within group
// - Automatic, forced locked/free-run/holdover settings
// - Reset free-run, acquire, then locked
// - Holdover to recover, recover back to holdover
// - Acquire returns free-run without references
//
// Implementation choices: the register offsets and register access over APB.
module operating_state_select_and_reference_select
	import dpll_select_pkg::*;
#(
	parameter int STEP_CYCLES = HISTORY_STEP_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_INPUTS-1:0] ref_valid,
	input wire logic [SEL_W-1:0] pin_manual_select_0,
	input wire logic pin_follower_status,
	input wire logic lock_detect,
	input wire logic [OFFSET_W-1:0] current_offset,
	input wire logic [OFFSET_W-1:0] filtered_offset,
	input wire logic [OFFSET_W-1:0] leader_offset,
	output logic [2:0] loop_state,
	output logic [1:0] loop_source,
	output logic [SEL_W-1:0] selected_ref,
	output logic ref_available,
	output logic [OFFSET_W-1:0] holdover_offset,
	output logic [OFFSET_W-1:0] freerun_offset,
	output logic integrator_load,
	output logic [3:0] loop_bandwidth,
	output logic [2:0] loop_damping,
	output logic [5:0] holdover_filter_bandwidth
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] control_0_reg;
	logic [3:0] reference_mode_select_reg;
	logic [NUM_INPUTS-1:0] input_enable_reg;
	logic [31:0] input_priority_table_reg;
	logic [31:0] input_group_reg;
	logic [7:0] reference_choice_reg;
	logic holdover_advanced_reg;
	logic [5:0] holdover_history_rate_reg;
	logic [5:0] holdover_filter_bw_reg;
	logic [3:0] bandwidth_reg;
	logic [2:0] damping_reg;
	logic [OFFSET_W-1:0] manual_holdover_offset_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	loop_state_t state_reg, state_next;
	logic [SEL_W-1:0] selected_reg;
	logic [OFFSET_W-1:0] holdover_offset_reg;
	logic [OFFSET_W-1:0] freerun_offset_reg;
	logic load_pending_reg;
	logic integrator_load_reg;
	logic [31:0] step_count_reg;
	logic [5:0] interval_count_reg;
	logic slot_ptr_reg;

	logic [NUM_INPUTS-1:0] qualified;
	logic [SEL_W-1:0] best_idx;
	logic best_found;
	logic [SEL_W-1:0] sel_next;
	logic avail;
	logic switching;
	logic holdover_entry;
	logic history_write;
	logic step_tick;
	logic [OFFSET_W-1:0] older_slot;
	logic wr_access;
	logic setup_phase;
	op_select_t op_select;
	logic revertive;

	assign op_select = op_select_t'(control_0_reg[CTL_STATE_LSB +: 3]);
	assign revertive = control_0_reg[CTL_REVERTIVE_BIT];
	assign setup_phase = psel & ~penable;
	assign wr_access = psel & penable & pwrite;

	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic [PRIO_W-1:0] prio_of(input logic [31:0] tbl, input logic [SEL_W-1:0] idx);
		return tbl[idx*PRIO_W +: PRIO_W];
	endfunction : prio_of

	// ----------------------------------------
	// APB write side
	// ----------------------------------------
	logic [31:0] wmerged;
	always_comb begin
		wmerged = 32'h0000_0000;
		if (paddr == CHANNEL_CONTROL_0_ADDR) begin
			wmerged = merge({24'h000000, control_0_reg}, pwdata, pstrb);
		end else if (paddr == REFERENCE_MODE_ADDR) begin
			wmerged = merge({28'h0000000, reference_mode_select_reg}, pwdata, pstrb);
		end else if (paddr == INPUT_ENABLE_ADDR) begin
			wmerged = merge({24'h000000, input_enable_reg}, pwdata, pstrb);
		end else if (paddr == INPUT_PRIORITY_ADDR) begin
			wmerged = merge(input_priority_table_reg, pwdata, pstrb);
		end else if (paddr == INPUT_GROUP_ADDR) begin
			wmerged = merge(input_group_reg, pwdata, pstrb);
		end else if (paddr == REFERENCE_CHOICE_ADDR) begin
			wmerged = merge({24'h000000, reference_choice_reg}, pwdata, pstrb);
		end else if (paddr == HOLDOVER_CONFIG_ADDR) begin
			wmerged = merge({10'h000, holdover_filter_bw_reg, 2'h0, holdover_history_rate_reg,
				7'h00, holdover_advanced_reg}, pwdata, pstrb);
		end else if (paddr == CHANNEL_CONTROL_2_ADDR) begin
			wmerged = merge({21'h000000, damping_reg, 4'h0, bandwidth_reg}, pwdata, pstrb);
		end else if (paddr == MANUAL_HOLDOVER_ADDR) begin
			wmerged = merge(manual_holdover_offset_reg, pwdata, pstrb);
		end
	end

	// Configuration registers, reset to defaults
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			control_0_reg <= CONTROL_0_RESET;
			reference_mode_select_reg <= REF_AUTOMATIC;
			input_enable_reg <= INPUT_ENABLE_RESET;
			input_priority_table_reg <= PRIORITY_RESET;
			input_group_reg <= GROUP_RESET;
			reference_choice_reg <= 8'h00;
			holdover_advanced_reg <= 1'b0;
			holdover_history_rate_reg <= HISTORY_RATE_RESET;
			holdover_filter_bw_reg <= 6'h00;
			bandwidth_reg <= BW_RESET;
			damping_reg <= DAMP_RESET;
			manual_holdover_offset_reg <= '0;
		end else if (wr_access) begin
			if (paddr == CHANNEL_CONTROL_0_ADDR) begin
				control_0_reg <= wmerged[7:0];
			end else if (paddr == REFERENCE_MODE_ADDR) begin
				reference_mode_select_reg <= wmerged[3:0];
			end else if (paddr == INPUT_ENABLE_ADDR) begin
				input_enable_reg <= wmerged[NUM_INPUTS-1:0];
			end else if (paddr == INPUT_PRIORITY_ADDR) begin
				input_priority_table_reg <= wmerged;
			end else if (paddr == INPUT_GROUP_ADDR) begin
				input_group_reg <= wmerged;
			end else if (paddr == REFERENCE_CHOICE_ADDR) begin
				reference_choice_reg <= {1'b0, wmerged[CHOICE_FOLLOWER_LSB +: SEL_W], 1'b0,
					wmerged[CHOICE_MANUAL_LSB +: SEL_W]};
			end else if (paddr == HOLDOVER_CONFIG_ADDR) begin
				holdover_advanced_reg <= wmerged[HO_ADVANCED_BIT];
				holdover_history_rate_reg <= wmerged[HO_RATE_LSB +: 6];
				holdover_filter_bw_reg <= wmerged[HO_FILTER_BW_LSB +: 6];
			end else if (paddr == CHANNEL_CONTROL_2_ADDR) begin
				bandwidth_reg <= wmerged[CTL2_BW_LSB +: 4];
				damping_reg <= wmerged[CTL2_DAMP_LSB +: 3];
			end else if (paddr == MANUAL_HOLDOVER_ADDR) begin
				manual_holdover_offset_reg <= wmerged;
			end
		end
	end

	// ----------------------------------------
	// APB read side, sampled in setup phase
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			if (paddr == CHANNEL_CONTROL_0_ADDR) begin
				prdata_reg <= {24'h000000, control_0_reg};
			end else if (paddr == REFERENCE_MODE_ADDR) begin
				prdata_reg <= {28'h0000000, reference_mode_select_reg};
			end else if (paddr == INPUT_ENABLE_ADDR) begin
				prdata_reg <= {24'h000000, input_enable_reg};
			end else if (paddr == INPUT_PRIORITY_ADDR) begin
				prdata_reg <= input_priority_table_reg;
			end else if (paddr == INPUT_GROUP_ADDR) begin
				prdata_reg <= input_group_reg;
			end else if (paddr == REFERENCE_CHOICE_ADDR) begin
				prdata_reg <= {24'h000000, reference_choice_reg};
			end else if (paddr == HOLDOVER_CONFIG_ADDR) begin
				prdata_reg <= {10'h000, holdover_filter_bw_reg, 2'h0, holdover_history_rate_reg,
					7'h00, holdover_advanced_reg};
			end else if (paddr == CHANNEL_CONTROL_2_ADDR) begin
				prdata_reg <= {21'h000000, damping_reg, 4'h0, bandwidth_reg};
			end else if (paddr == MANUAL_HOLDOVER_ADDR) begin
				prdata_reg <= manual_holdover_offset_reg;
			end else if (paddr == STATUS_ADDR) begin
				prdata_reg <= {16'h0000, qualified, avail, selected_reg, 1'b0, state_reg};
				pslverr_reg <= pwrite; // Status is read-only
			end else if (paddr == HOLDOVER_VALUE_ADDR) begin
				prdata_reg <= holdover_offset_reg;
				pslverr_reg <= pwrite;
			end else begin
				pslverr_reg <= 1'b1; // Unmapped
			end
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;

	// ----------------------------------------
	// Reference selection
	// ----------------------------------------
	// Qualified inputs: enabled and reported valid
	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_qual
			assign qualified[gi] = input_enable_reg[gi] & ref_valid[gi];
		end
	endgenerate

	// Best qualified input, lower priority value wins, ties to lower index
	always_comb begin
		best_idx = '0;
		best_found = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (qualified[i] && (!best_found ||
				prio_of(input_priority_table_reg, SEL_W'(i)) < prio_of(input_priority_table_reg, best_idx))) begin
				best_idx = SEL_W'(i);
				best_found = 1'b1;
			end
		end
	end

	// Next reference and availability per reference mode
	always_comb begin
		logic cur_ok;
		logic better;
		logic same_group;
		logic [3:0] grp_best;
		logic [3:0] grp_cur;
		cur_ok = qualified[selected_reg];
		grp_best = input_group_reg[best_idx*4 +: 4];
		grp_cur = input_group_reg[selected_reg*4 +: 4];
		same_group = (grp_best != 4'h0) && (grp_best == grp_cur);
		better = prio_of(input_priority_table_reg, best_idx) < prio_of(input_priority_table_reg, selected_reg);
		sel_next = selected_reg;
		avail = 1'b0;
		case (reference_mode_select_reg)
			REF_MANUAL: begin
				sel_next = reference_choice_reg[CHOICE_MANUAL_LSB +: SEL_W];
				avail = ref_valid[sel_next];
			end
			REF_PIN: begin
				sel_next = pin_manual_select_0;
				avail = ref_valid[sel_next];
			end
			REF_FOLLOWER: begin
				sel_next = reference_choice_reg[CHOICE_FOLLOWER_LSB +: SEL_W];
				avail = ref_valid[sel_next];
			end
			REF_AUTOMATIC, REF_PIN_FOLLOWER: begin
				if (reference_mode_select_reg == REF_PIN_FOLLOWER && pin_follower_status) begin
					sel_next = reference_choice_reg[CHOICE_FOLLOWER_LSB +: SEL_W];
					avail = ref_valid[sel_next];
				end else if (!cur_ok) begin
					sel_next = best_idx;
					avail = best_found;
				end else begin
					avail = 1'b1;
					if (revertive && better && !same_group) begin
						sel_next = best_idx;
					end
				end
			end
			default: begin
				avail = 1'b0; // Reserved codes select nothing
			end
		endcase
	end

	assign switching = avail && (sel_next != selected_reg);

	// Selected reference, held while none is available
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			selected_reg <= '0;
		end else if (avail) begin
			selected_reg <= sel_next;
		end
	end

	// ----------------------------------------
	// Operating state machine
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (op_select)
			OP_FORCED_LOCKED: begin
				state_next = ST_LOCKED;
			end
			OP_FORCED_FREERUN: begin
				state_next = ST_FREERUN;
			end
			OP_FORCED_HOLDOVER, OP_MANUAL_HOLDOVER: begin
				state_next = ST_HOLDOVER;
			end
			default: begin
				case (state_reg)
					ST_FREERUN: begin
						if (avail) begin
							state_next = ST_LOCK_ACQUIRE;
						end
					end
					ST_LOCK_ACQUIRE: begin
						if (!avail) begin
							state_next = ST_FREERUN;
						end else if (lock_detect && !switching) begin
							state_next = ST_LOCKED;
						end
					end
					ST_LOCKED: begin
						if (!avail) begin
							state_next = ST_HOLDOVER;
						end else if (switching) begin
							state_next = ST_LOCK_RECOVER;
						end
					end
					ST_HOLDOVER: begin
						if (avail) begin
							state_next = ST_LOCK_RECOVER;
						end
					end
					ST_LOCK_RECOVER: begin
						if (!avail) begin
							state_next = ST_HOLDOVER;
						end else if (lock_detect && !switching) begin
							state_next = ST_LOCKED;
						end
					end
					default: begin
						state_next = ST_FREERUN;
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_FREERUN;
		end else begin
			state_reg <= state_next;
		end
	end

	assign holdover_entry = (state_next == ST_HOLDOVER) && (state_reg != ST_HOLDOVER);

	// ----------------------------------------
	// Holdover history
	// ----------------------------------------
	// One-second step counter
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			step_count_reg <= 32'h0000_0000;
		end else if (step_count_reg >= 32'(STEP_CYCLES - 1)) begin
			step_count_reg <= 32'h0000_0000;
		end else begin
			step_count_reg <= step_count_reg + 32'h0000_0001;
		end
	end

	assign step_tick = (step_count_reg >= 32'(STEP_CYCLES - 1));

	// Interval in steps; zero saves every cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			interval_count_reg <= 6'h00;
		end else if (state_reg != ST_LOCKED || history_write) begin
			interval_count_reg <= 6'h00;
		end else if (step_tick) begin
			interval_count_reg <= interval_count_reg + 6'h01;
		end
	end

	assign history_write = (state_reg == ST_LOCKED) && ((holdover_history_rate_reg == 6'h00) ||
		(step_tick && interval_count_reg + 6'h01 >= holdover_history_rate_reg));

	// Write pointer always addresses the older slot
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			slot_ptr_reg <= 1'b0;
		end else if (history_write) begin
			slot_ptr_reg <= ~slot_ptr_reg;
		end
	end

	history_store u_history (
		.core_clk(core_clk),
		.reset(reset),
		.wr_en(history_write),
		.wr_addr(slot_ptr_reg),
		.wr_data(filtered_offset),
		.rd_addr(slot_ptr_reg),
		.rd_data(older_slot)
	);

	// ----------------------------------------
	// Holdover value and integrator load
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			holdover_offset_reg <= '0;
			load_pending_reg <= 1'b0;
			integrator_load_reg <= 1'b0;
		end else begin
			load_pending_reg <= 1'b0;
			integrator_load_reg <= 1'b0;
			if (op_select == OP_MANUAL_HOLDOVER) begin
				holdover_offset_reg <= manual_holdover_offset_reg;
			end else if (holdover_entry && !holdover_advanced_reg) begin
				holdover_offset_reg <= current_offset;
				integrator_load_reg <= 1'b1;
			end else if (holdover_entry) begin
				load_pending_reg <= 1'b1; // Older slot arrives next cycle
			end else if (load_pending_reg) begin
				holdover_offset_reg <= older_slot;
				integrator_load_reg <= 1'b1;
			end
		end
	end

	// Free-run offset: zero, or the leader's input in combo
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			freerun_offset_reg <= '0;
		end else if (control_0_reg[CTL_COMBO_BIT]) begin
			freerun_offset_reg <= leader_offset;
		end else begin
			freerun_offset_reg <= '0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		case (state_reg)
			ST_HOLDOVER: loop_source = SRC_HOLDOVER;
			ST_FREERUN: loop_source = SRC_OSCILLATOR;
			default: loop_source = SRC_REFERENCE;
		endcase
	end

	assign loop_state = state_reg;
	assign selected_ref = selected_reg;
	assign ref_available = avail;
	assign holdover_offset = holdover_offset_reg;
	assign freerun_offset = freerun_offset_reg;
	assign integrator_load = integrator_load_reg;
	assign loop_bandwidth = bandwidth_reg;
	assign loop_damping = damping_reg;
	assign holdover_filter_bandwidth = holdover_filter_bw_reg;

endmodule : operating_state_select_and_reference_select

// >>> dpll_select_sva.sv
module dpll_select_chk
	import dpll_select_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pslverr,
	input wire logic lock_detect,
	input wire logic [2:0] loop_state,
	input wire logic [1:0] loop_source,
	input wire logic ref_available,
	input wire logic integrator_load
);
	// Shadow of the operating state select
	logic [2:0] op;
	logic auto_op;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) op <= 3'h0;
		else if (psel && penable && pwrite && pstrb[0] && paddr == CHANNEL_CONTROL_0_ADDR) op <= pwdata[2:0];
	end
	assign auto_op = op == OP_AUTOMATIC;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_freerun_osc: assert property (loop_state == ST_FREERUN |-> loop_source == SRC_OSCILLATOR)
		else $error("free-run not on oscillator");
	a_locked_ref: assert property (loop_state == ST_LOCKED |-> loop_source == SRC_REFERENCE)
		else $error("locked not on reference");
	a_lock_gain: assert property (auto_op && loop_state == ST_LOCK_ACQUIRE && lock_detect && ref_available
		|=> loop_state == ST_LOCKED) else $error("lock not taken");
	a_hold_entry: assert property (auto_op && loop_state == ST_LOCKED && !ref_available
		|=> loop_state == ST_HOLDOVER) else $error("holdover not entered");
	a_acq_fallback: assert property (auto_op && loop_state == ST_LOCK_ACQUIRE && !ref_available
		|=> loop_state == ST_FREERUN) else $error("acquire did not fall back");
	a_hold_recover: assert property (auto_op && loop_state == ST_HOLDOVER && ref_available
		|=> loop_state == ST_LOCK_RECOVER) else $error("recovery not started");
	a_forced_hold: assert property (op == OP_FORCED_HOLDOVER || op == OP_MANUAL_HOLDOVER
		|=> loop_state == ST_HOLDOVER) else $error("forced holdover left");
	a_hold_load: assert property ($rose(loop_state == ST_HOLDOVER) && $past(loop_state) == ST_LOCKED && auto_op
		|-> ##[0:2] integrator_load) else $error("integrator not loaded");
	a_load_pulse: assert property (integrator_load |=> !integrator_load)
		else $error("load pulse too long");
	a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
	a_unmapped: assert property (psel && penable && paddr > HOLDOVER_VALUE_ADDR |-> pslverr)
		else $error("unmapped access accepted");
endmodule : dpll_select_chk

bind operating_state_select_and_reference_select dpll_select_chk i_chk (.core_clk, .reset, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pslverr, .lock_detect, .loop_state, .loop_source, .ref_available, .integrator_load);

// >>> loop_partner.sv
module loop_partner
	import dpll_select_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] loop_state,
	output logic lock_detect,
	output logic [OFFSET_W-1:0] current_offset,
	output logic [OFFSET_W-1:0] filtered_offset
);
	logic [3:0] pull_cnt;
	// Loop pulls in a few cycles after acquiring or recovering
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) pull_cnt <= 4'h0;
		else if (loop_state == ST_LOCK_ACQUIRE || loop_state == ST_LOCK_RECOVER) pull_cnt <= pull_cnt + 4'h1;
		else pull_cnt <= 4'h0;
	end
	assign lock_detect = pull_cnt >= 4'h4 || loop_state == ST_LOCKED;
	// Offset drifts; filtered copy drifts more slowly, in every loop state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) {current_offset, filtered_offset} <= '0;
		else {current_offset, filtered_offset} <= {current_offset + 32'h13, filtered_offset + 32'h2};
	end
endmodule : loop_partner

// >>> test_operating_state_select_and_reference_select.sv
module test_operating_state_select_and_reference_select;
	timeunit 1ns;
	timeprecision 1ps;
	import dpll_select_pkg::*;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, pin_follower_status, lock_detect;
	logic ref_available, integrator_load, err;
	logic [7:0] paddr, ref_valid, v;
	logic [31:0] pwdata, prdata, current_offset, filtered_offset, leader_offset, holdover_offset;
	logic [31:0] freerun_offset, rd, w32;
	logic [3:0] pstrb, loop_bandwidth;
	logic [2:0] pin_manual_select_0, loop_state, selected_ref, loop_damping, s;
	logic [1:0] loop_source;
	logic [5:0] holdover_filter_bandwidth;
	int n_errors = 0;
	int samples_checked = 0;
	operating_state_select_and_reference_select #(.STEP_CYCLES(10)) i_dut (.*);
	loop_partner i_partner (.*);
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One APB transfer, setup then access until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// Highest priority qualified input under reset priorities
	function automatic logic [2:0] exp_sel(input logic [7:0] q);
		exp_sel = 3'h0;
		for (int i = 7; i >= 0; i--) if (q[i]) exp_sel = i[2:0];
	endfunction : exp_sel
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	// Watchdog
	initial begin
		cyc(20000);
		n_errors++;
		end_sim;
	end
	// Main sequence
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 8'h00, 32'h0, 4'hF};
		{s, ref_valid, pin_manual_select_0, pin_follower_status, leader_offset} = '0;
		void'($urandom(32'hddc338c2));
		cyc(20);
		reset <= 1'b0;
		cyc(1);
		chk("state", ST_FREERUN, loop_state);
		apb(0, INPUT_ENABLE_ADDR, 0);
		chk("enable", 32'h0000_00FF, rd);
		apb(0, INPUT_PRIORITY_ADDR, 0);
		chk("priority", PRIORITY_RESET, rd);
		apb(0, 8'h40, 0);
		chk("unmapped", 1, err);
		apb(1, STATUS_ADDR, 0);
		chk("ro write", 1, err);
		apb(1, HOLDOVER_CONFIG_ADDR, 32'h002A_0301);
		apb(1, CHANNEL_CONTROL_2_ADDR, 32'h0000_050B);
		cyc(1);
		chk("bw", 4'hB, loop_bandwidth);
		chk("damp", 3'h5, loop_damping);
		chk("ho bw", 6'h2A, holdover_filter_bandwidth);
		repeat (8) begin
			v = 8'($urandom_range(255, 1));
			ref_valid <= v;
			cyc(14);
			s = v[s] ? s : exp_sel(v);
			chk("auto sel", s, selected_ref);
			chk("locked", ST_LOCKED, loop_state);
			ref_valid <= 8'h00;
			cyc(6);
			chk("holdover", ST_HOLDOVER, loop_state);
		end
		apb(1, INPUT_GROUP_ADDR, 32'h0000_1001);
		apb(1, CHANNEL_CONTROL_0_ADDR, 32'h8);
		ref_valid <= 8'h08;
		cyc(14);
		ref_valid <= 8'h09;
		cyc(14);
		chk("group", 3, selected_ref);
		apb(1, INPUT_GROUP_ADDR, 0);
		cyc(14);
		chk("revert", 0, selected_ref);
		apb(1, CHANNEL_CONTROL_0_ADDR, 0);
		ref_valid <= 8'h08;
		cyc(14);
		ref_valid <= 8'h09;
		cyc(14);
		chk("nonrevert", 3, selected_ref);
		{pin_manual_select_0, pin_follower_status, ref_valid} <= {3'h6, 1'b1, 8'hFF};
		apb(1, REFERENCE_CHOICE_ADDR, 32'h45);
		for (int m = 1; m < 5; m++) begin
			apb(1, REFERENCE_MODE_ADDR, m);
			cyc(14);
			chk("mode sel", m == 1 ? 5 : m == 2 ? 6 : 4, selected_ref);
		end
		apb(1, REFERENCE_MODE_ADDR, 1);
		cyc(14);
		ref_valid <= 8'hDF;
		cyc(4);
		chk("manual lost", ST_HOLDOVER, loop_state);
		apb(1, REFERENCE_MODE_ADDR, 32'h9);
		ref_valid <= 8'hFF;
		cyc(3);
		chk("reserved", 0, ref_available);
		apb(1, REFERENCE_MODE_ADDR, 0);
		apb(1, CHANNEL_CONTROL_0_ADDR, 32'h3);
		cyc(14);
		chk("forced hold", ST_HOLDOVER, loop_state);
		w32 = $urandom;
		apb(1, MANUAL_HOLDOVER_ADDR, w32);
		apb(1, CHANNEL_CONTROL_0_ADDR, 32'h4);
		cyc(3);
		chk("manual offset", w32, holdover_offset);
		leader_offset <= $urandom;
		apb(1, CHANNEL_CONTROL_0_ADDR, 32'h12);
		cyc(3);
		chk("source", SRC_OSCILLATOR, loop_source);
		chk("combo", leader_offset, freerun_offset);
		end_sim;
	end
endmodule : test_operating_state_select_and_reference_select
